// *** rtl/pst_device_test.sv ***
`timescale 1ns/10ps
module pst_device_test
    import pst_pkg::*;
#(
    parameter int CUR_W = 12
)(
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_start_t1,
    input  wire logic             i_start_t2,
    input  wire logic             i_stop,
    input  wire logic             i_torque_off_enable_a,
    input  wire logic             i_torque_off_enable_b,
    input  wire logic             i_perm_fault,
    input  wire logic             i_internal_fault,
    input  wire logic [CUR_W-1:0] i_rated_peak,
    input  wire logic [CUR_W-1:0] i_current_abs,
    input  wire logic             i_hw_short_trip,
    input  wire logic             i_hw_earth_trip,
    input  wire logic             i_dclink_rise,
    input  wire logic             i_volt_at_cap,
    output logic [5:0]            o_switch_on,
    output logic                  o_dc_active,
    output logic                  o_dc_neg,
    output logic [CUR_W-1:0]      o_dc_target,
    output logic [15:0]           o_status,
    output logic                  o_busy
);
    pst_state_type    st_q, st_d;
    logic             t2_q, t2_d;
    logic [2:0]       step_q, step_d;
    logic [15:0]      msg_q, msg_d;
    logic             tload;
    logic [15:0]      tcount;
    logic             tdone;
    logic [1:0]       br;
    logic             neg;
    logic [CUR_W+7:0] lim_wide;
    logic [CUR_W-1:0] over_lim;
    logic             over;

    // step number: test one 0..5 = switch, test two 0..5 = branch*2+pol
    assign br  = t2_q ? 2'(step_q >> 1) : 2'(step_q % 3'h3);
    assign neg = t2_q ? step_q[0] : (step_q >= 3'h3);

    assign lim_wide = (CUR_W+8)'(i_rated_peak) * (CUR_W+8)'(PST_OVER_NUM) / (CUR_W+8)'(100);
    // saturate so a large rating cannot wrap the limit to a small value
    always_comb
    begin
        over_lim = CUR_W'(lim_wide);
        if (lim_wide > (CUR_W+8)'({CUR_W{1'b1}}))
        begin
            over_lim = '1;
        end
    end
    assign over     = i_current_abs > over_lim;

    pst_step_timer #(
        .WIDTH (16)
    ) u_timer (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_load  (tload),
        .i_count (tcount),
        .o_busy  (),
        .o_done  (tdone)
    );

    always_comb
    begin
        st_d   = st_q;
        t2_d   = t2_q;
        step_d = step_q;
        msg_d  = msg_q;
        tload  = 1'b0;
        tcount = 16'(PST_PULSE_CYC);
        case (st_q)
            PST_IDLE:
            begin
                if (i_start_t1 || i_start_t2)
                begin
                    t2_d   = i_start_t2 && !i_start_t1;
                    step_d = PST_STEP_RST;
                    msg_d  = PST_MSG_NONE;
                    st_d   = PST_CHECK;
                end
            end
            PST_CHECK:
            begin
                if (i_perm_fault)
                begin
                    msg_d = PST_MSG_PERM;
                    st_d  = PST_HALT;
                end
                else if (!i_torque_off_enable_a || !i_torque_off_enable_b)
                begin
                    msg_d = PST_MSG_STO;
                    st_d  = PST_HALT;
                end
                else if (i_current_abs != '0)
                begin
                    msg_d = PST_MSG_PRECUR;
                    st_d  = PST_HALT;
                end
                else
                begin
                    tload = 1'b1;
                    st_d  = PST_PULSE;
                end
            end
            PST_PULSE:
            begin
                if (tdone)
                begin
                    st_d = PST_EVAL;
                end
            end
            PST_EVAL:
            begin
                st_d = PST_NEXT;
                if (!t2_q)
                begin
                    if (i_hw_short_trip || i_hw_earth_trip || over)
                    begin
                        msg_d = (neg ? PST_MSG_T1_N : PST_MSG_T1_P) + 16'(br);
                        st_d  = PST_HALT;
                    end
                    else if (i_current_abs != '0 && !neg)
                    begin
                        msg_d = PST_MSG_T1_SP + 16'(br);
                        st_d  = PST_HALT;
                    end
                end
                else
                begin
                    if (i_hw_short_trip)
                    begin
                        msg_d = PST_MSG_SHORT + 16'(br) + (neg ? PST_MSG_NEG : 16'h0);
                        st_d  = PST_HALT;
                    end
                    else if (i_hw_earth_trip)
                    begin
                        msg_d = PST_MSG_EARTH + 16'(br) + (neg ? PST_MSG_NEG : 16'h0);
                        st_d  = PST_HALT;
                    end
                    else if (i_dclink_rise)
                    begin
                        msg_d = PST_MSG_SOFT + 16'(br) + (neg ? PST_MSG_NEG : 16'h0);
                        st_d  = PST_HALT;
                    end
                    else if (i_volt_at_cap || i_current_abs < o_dc_target)
                    begin
                        msg_d = PST_MSG_OPEN + 16'(br) + (neg ? PST_MSG_NEG : 16'h0);
                        st_d  = PST_HALT;
                    end
                end
            end
            PST_NEXT:
            begin
                if (step_q == PST_STEPS - 3'h1)
                begin
                    msg_d = t2_q ? PST_MSG_PASS2 : PST_MSG_PASS1;
                    st_d  = PST_DONE;
                end
                else
                begin
                    step_d = step_q + 3'h1;
                    tload  = 1'b1;
                    st_d   = PST_PULSE;
                end
            end
            PST_HALT:
            begin
                if (i_start_t1 || i_start_t2)
                begin
                    st_d = PST_IDLE;
                end
            end
            default:
            begin
                if (i_start_t1 || i_start_t2)
                begin
                    st_d = PST_IDLE;
                end
            end
        endcase
        if (st_q != PST_IDLE && st_q != PST_HALT && st_q != PST_DONE)
        begin
            if (i_internal_fault)
            begin
                msg_d = PST_MSG_INT;
                st_d  = PST_HALT;
            end
            else if (i_stop)
            begin
                msg_d = PST_MSG_STOP;
                st_d  = PST_HALT;
            end
            else if (i_perm_fault)
            begin
                msg_d = PST_MSG_PERM;
                st_d  = PST_HALT;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            st_q   <= PST_IDLE;
            t2_q   <= 1'b0;
            step_q <= PST_STEP_RST;
            msg_q  <= PST_MSG_NONE;
        end
        else
        begin
            st_q   <= st_d;
            t2_q   <= t2_d;
            step_q <= step_d;
            msg_q  <= msg_d;
        end
    end

    // drive stays on through eval so the check sees the live current
    always_comb
    begin
        o_switch_on = 6'h00;
        o_dc_active = 1'b0;
        if (st_q == PST_PULSE || st_q == PST_EVAL)
        begin
            if (t2_q)
            begin
                o_dc_active = 1'b1;
            end
            else
            begin
                o_switch_on = 6'(6'h01 << step_q);
            end
        end
    end

    assign o_dc_neg    = neg;
    assign o_dc_target = i_rated_peak >> PST_QUART_DIV;
    assign o_status    = msg_q;
    assign o_busy      = (st_q != PST_IDLE) && (st_q != PST_HALT) && (st_q != PST_DONE);

    property p_sto;
        @(posedge i_clk) disable iff (!i_rst_n)
        st_q == PST_CHECK && !i_perm_fault && !i_torque_off_enable_a
        && !i_internal_fault && !i_stop
        |=> msg_q == PST_MSG_STO && st_q == PST_HALT;
    endproperty
    a_sto: assert property (p_sto) else $error("torque-off code missing");
    property p_one_switch;
        @(posedge i_clk) disable iff (!i_rst_n) $onehot0(o_switch_on);
    endproperty
    a_one_switch: assert property (p_one_switch) else $error("more than one switch on");
    property p_stop;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_busy && i_stop && !i_internal_fault |=> msg_q == PST_MSG_STOP;
    endproperty
    a_stop: assert property (p_stop) else $error("stop code missing");
    property p_perm;
        @(posedge i_clk) disable iff (!i_rst_n)
        st_q == PST_CHECK && i_perm_fault |=> !o_busy ##1 o_switch_on == 6'h00;
    endproperty
    a_perm: assert property (p_perm) else $error("test ran with permanent fault");
    property p_int;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_busy && i_internal_fault |=> msg_q == PST_MSG_INT && !o_busy;
    endproperty
    a_int: assert property (p_int) else $error("internal error code missing");
    property p_precur;
        @(posedge i_clk) disable iff (!i_rst_n)
        st_q == PST_CHECK && !i_perm_fault && i_torque_off_enable_a && i_torque_off_enable_b
        && i_current_abs != '0 && !i_internal_fault && !i_stop |=> msg_q == PST_MSG_PRECUR;
    endproperty
    a_precur: assert property (p_precur) else $error("start current code missing");
    property p_t1_halt;
        @(posedge i_clk) disable iff (!i_rst_n)
        st_q == PST_EVAL && !t2_q && over |=> st_q == PST_HALT && o_switch_on == 6'h00;
    endproperty
    a_t1_halt: assert property (p_t1_halt) else $error("test one went on after a short");
    property p_t2_short;
        @(posedge i_clk) disable iff (!i_rst_n)
        st_q == PST_EVAL && t2_q && i_hw_short_trip && !i_internal_fault && !i_stop
        && !i_perm_fault |=> msg_q[15:4] == 12'h021;
    endproperty
    a_t2_short: assert property (p_t2_short) else $error("short cutoff code missing");
    property p_t2_cap;
        @(posedge i_clk) disable iff (!i_rst_n)
        st_q == PST_EVAL && t2_q && i_volt_at_cap && !i_hw_short_trip && !i_hw_earth_trip
        && !i_dclink_rise && !i_internal_fault && !i_stop && !i_perm_fault
        |=> msg_q[15:4] == 12'h020;
    endproperty
    a_t2_cap: assert property (p_t2_cap) else $error("open code missing at voltage cap");
    c_t1_pass:  cover property (@(posedge i_clk) msg_q == PST_MSG_PASS1);
    c_t2_pass:  cover property (@(posedge i_clk) msg_q == PST_MSG_PASS2);
    c_open:     cover property (@(posedge i_clk) msg_q == PST_MSG_OPEN);
    c_stop:     cover property (@(posedge i_clk) msg_q == PST_MSG_STOP);
    c_t1_fault: cover property (@(posedge i_clk) msg_q == PST_MSG_T1_P);
endmodule

// *** rtl/pst_pkg.sv ***
// Summary of operation
// - test one pulses six switches singly
// - current above peak plus ten percent: short to a rail
// - short to a rail halts test one
// - codes 0101..0103 for shorts to negative rail
// - codes 0104..0106 for shorts to positive rail
// - codes 0114..0116 for soft positive shorts
// - operator stop ends with code 0001
// - permanent fault: code 0002, no test
// - missing torque-off enable: code 0003
// - current at start: code 0010
// - internal failure reports internal error code
// - test two drives both polarities per branch
// - test two target is quarter peak
// - voltage capped; unreachable target reports the branch under test open
// - open codes 0201..0206
// - short cutoff codes 0211..0216
// - earth cutoff codes 0221..0226
// - dc-link rise codes 0231..0236
// - status word shows message and pass codes, not the step in progress
package pst_pkg;
    typedef enum logic [3:0] {
        PST_IDLE  = 4'h0,
        PST_CHECK = 4'h1,
        PST_PULSE = 4'h3,
        PST_EVAL  = 4'h2,
        PST_NEXT  = 4'h6,
        PST_HALT  = 4'h7,
        PST_DONE  = 4'h5
    } pst_state_type;

    localparam logic [15:0] PST_MSG_NONE   = 16'h0000;
    localparam logic [15:0] PST_MSG_STOP   = 16'h0001;
    localparam logic [15:0] PST_MSG_PERM   = 16'h0002;
    localparam logic [15:0] PST_MSG_STO    = 16'h0003;
    localparam logic [15:0] PST_MSG_PRECUR = 16'h0010;
    localparam logic [15:0] PST_MSG_T1_N   = 16'h0101;
    localparam logic [15:0] PST_MSG_T1_P   = 16'h0104;
    localparam logic [15:0] PST_MSG_T1_SP  = 16'h0114;
    localparam logic [15:0] PST_MSG_OPEN   = 16'h0201;
    localparam logic [15:0] PST_MSG_SHORT  = 16'h0211;
    localparam logic [15:0] PST_MSG_EARTH  = 16'h0221;
    localparam logic [15:0] PST_MSG_SOFT   = 16'h0231;
    localparam logic [15:0] PST_MSG_NEG    = 16'h0003;
    localparam logic [15:0] PST_MSG_INT    = 16'hfe41;
    localparam logic [15:0] PST_MSG_PASS1  = 16'h0f01;
    localparam logic [15:0] PST_MSG_PASS2  = 16'h0f02;

    localparam int          PST_PULSE_NS   = 10000;
    localparam int          PST_CLK_NS     = 10;
    localparam int          PST_PULSE_CYC  = (PST_PULSE_NS + PST_CLK_NS - 1) / PST_CLK_NS;
    localparam int          PST_SETTLE_NS  = 1000;
    localparam int          PST_SETTLE_CYC = (PST_SETTLE_NS + PST_CLK_NS - 1) / PST_CLK_NS;
    localparam logic [2:0]  PST_STEP_RST   = 3'h0;
    localparam logic [2:0]  PST_STEPS      = 3'h6;
    localparam logic [7:0]  PST_OVER_NUM   = 8'h6e;
    localparam logic [7:0]  PST_QUART_DIV  = 8'h02;
endpackage

// *** rtl/pst_step_timer.sv ***
`timescale 1ns/10ps
module pst_step_timer
    import pst_pkg::*;
#(
    parameter int WIDTH = 16
)(
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_load,
    input  wire logic [WIDTH-1:0] i_count,
    output logic                  o_busy,
    output logic                  o_done
);
    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;
    logic             done_q;
    logic             done_d;

    always_comb
    begin
        cnt_d  = cnt_q;
        done_d = 1'b0;
        if (i_load)
        begin
            cnt_d = i_count;
        end
        else if (cnt_q != '0)
        begin
            cnt_d  = cnt_q - 1'b1;
            done_d = (cnt_q == {{(WIDTH-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            cnt_q  <= '0;
            done_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            done_q <= done_d;
        end
    end

    assign o_busy = (cnt_q != '0);
    assign o_done = done_q;
endmodule

// *** test/pst_load_model.sv ***
`timescale 1ns/10ps
module pst_load_model
    import pst_pkg::*;
#(
    parameter int CUR_W = 12
)(
    input  wire logic             i_clk,
    input  wire logic [5:0]       i_switch_on,
    input  wire logic             i_dc_active,
    input  wire logic             i_dc_neg,
    input  wire logic [CUR_W-1:0] i_dc_target,
    input  wire logic [CUR_W-1:0] i_rated_peak,
    input  wire logic [3:0]       i_fault_kind,
    input  wire logic [2:0]       i_fault_at,
    output logic [CUR_W-1:0]      o_current_abs,
    output logic                  o_short_trip,
    output logic                  o_earth_trip,
    output logic                  o_dclink_rise,
    output logic                  o_volt_at_cap
);
    logic hit;

    // fault hits one switch in test one, one polarity in test two
    always_comb hit = i_switch_on[i_fault_at] || (i_dc_active && i_dc_neg == i_fault_at[0]);

    always @(negedge i_clk)
    begin
        o_current_abs <= i_dc_active ? i_dc_target : '0;
        o_short_trip  <= 1'b0;
        o_earth_trip  <= 1'b0;
        o_dclink_rise <= 1'b0;
        o_volt_at_cap <= i_fault_kind == 4'h7 && i_dc_active;
        if (i_fault_kind == 4'h8)
            o_current_abs <= CUR_W'(12'h032);
        else if (hit)
        begin
            case (i_fault_kind)
                4'h1: o_current_abs <= i_rated_peak + (i_rated_peak >> 3);
                4'h2: o_current_abs <= CUR_W'(12'h032);
                4'h3: o_current_abs <= '0;
                4'h4: o_short_trip <= 1'b1;
                4'h5: o_earth_trip <= 1'b1;
                4'h6: o_dclink_rise <= 1'b1;
                4'h9: o_current_abs <= i_rated_peak + i_rated_peak / CUR_W'(10);
                default: ;
            endcase
        end
    end
endmodule

// *** test/tb_power_stage_device_test.sv ***
`timescale 1ns/10ps
module tb_power_stage_device_test
    import pst_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0, st1 = 1'b0, st2 = 1'b0, stop = 1'b0;
    logic        sto_a = 1'b1, sto_b = 1'b1, perm = 1'b0, intf = 1'b0;
    logic [11:0] peak = 12'h400, cur, tgt, tgt_seen;
    logic        strip, etrip, rise, cap, dca, dcn, dca_q = 1'b0, dcn_q, busy;
    logic [5:0]  sw, sw_q = 6'h00;
    logic [15:0] status;
    logic [3:0]  fkind = 4'h0;
    logic [2:0]  fat = 3'h0;
    logic [5:0]  sw_log[$];
    logic        pol_log[$];
    int          failures = 0;
    int          comparisons = 0;

    always #5 clk = ~clk;

    pst_device_test #(.CUR_W(12)) dut (.i_clk(clk), .i_rst_n(rst_n), .i_start_t1(st1),
        .i_start_t2(st2), .i_stop(stop), .i_torque_off_enable_a(sto_a),
        .i_torque_off_enable_b(sto_b), .i_perm_fault(perm), .i_internal_fault(intf),
        .i_rated_peak(peak), .i_current_abs(cur), .i_hw_short_trip(strip),
        .i_hw_earth_trip(etrip), .i_dclink_rise(rise), .i_volt_at_cap(cap),
        .o_switch_on(sw), .o_dc_active(dca), .o_dc_neg(dcn), .o_dc_target(tgt),
        .o_status(status), .o_busy(busy));

    pst_load_model #(.CUR_W(12)) load (.i_clk(clk), .i_switch_on(sw), .i_dc_active(dca),
        .i_dc_neg(dcn), .i_dc_target(tgt), .i_rated_peak(peak), .i_fault_kind(fkind),
        .i_fault_at(fat), .o_current_abs(cur), .o_short_trip(strip), .o_earth_trip(etrip),
        .o_dclink_rise(rise), .o_volt_at_cap(cap));

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // log each new switch pulse and each new test-two polarity
    always @(posedge clk)
    begin
        if ($countones(sw) > 1)
            check("switch_onehot", {10'h000, sw}, 16'h0000);
        if (sw != 6'h00 && sw !== sw_q)
            sw_log.push_back(sw);
        if (dca && (!dca_q || dcn !== dcn_q))
        begin
            pol_log.push_back(dcn);
            tgt_seen <= tgt;
        end
        sw_q  <= sw;
        dca_q <= dca;
        dcn_q <= dcn;
    end

    // first start cycle leaves a halted run, second one starts from idle
    task automatic run(input logic two, input logic [15:0] exp, input string name);
        int n;
        n = 0;
        sw_log.delete();
        pol_log.delete();
        st1 = !two;
        st2 = two;
        repeat (2) @(negedge clk);
        st1 = 1'b0;
        st2 = 1'b0;
        repeat (3) @(negedge clk);
        while (busy !== 1'b0 && n < 8000)
        begin
            @(negedge clk);
            n++;
        end
        check(name, status, exp);
        check("switch_idle", {10'h000, sw}, 16'h0000);
    endtask

    task automatic t_refuse;
        check("reset_status", status, PST_MSG_NONE);
        check("reset_idle", {15'h0000, busy}, 16'h0000);
        sto_a = 1'b0;
        run(1'b0, PST_MSG_STO, "sto_a");
        sto_a = 1'b1;
        sto_b = 1'b0;
        run(1'b1, PST_MSG_STO, "sto_b");
        sto_b = 1'b1;
        perm = 1'b1;
        run(1'b0, PST_MSG_PERM, "perm");
        check("perm_no_pulse", 16'(sw_log.size()), 16'h0000);
        perm = 1'b0;
        fkind = 4'h8;
        run(1'b1, PST_MSG_PRECUR, "precur");
        fkind = 4'h0;
    endtask

    task automatic t1_pass;
        run(1'b0, PST_MSG_PASS1, "t1_pass");
        check("t1_steps", 16'(sw_log.size()), 16'h0006);
        foreach (sw_log[i])
            check("t1_order", {10'h000, sw_log[i]}, 16'h0001 << i);
    endtask

    task automatic t1_faults;
        logic [3:0]  k[5] = '{4'h1, 4'h1, 4'h1, 4'h2, 4'h9};
        logic [2:0]  a[5] = '{3'h0, 3'h4, 3'h5, 3'h2, 3'h0};
        logic [15:0] e[5] = '{16'h0104, 16'h0102, 16'h0103, 16'h0116, 16'h0114};
        for (int i = 0; i < 5; i++)
        begin
            fkind = k[i];
            fat = a[i];
            run(1'b0, e[i], "t1_fault");
            check("t1_halt", 16'(sw_log.size()), 16'(a[i] + 1));
        end
        fkind = 4'h0;
    endtask

    task automatic t2_pass;
        run(1'b1, PST_MSG_PASS2, "t2_pass");
        check("t2_target", {4'h0, tgt_seen}, {4'h0, peak >> 2});
        check("t2_steps", 16'(pol_log.size()), 16'h0006);
        foreach (pol_log[i])
            check("t2_polarity", {15'h0000, pol_log[i]}, 16'(i % 2));
    endtask

    task automatic t2_faults;
        logic [15:0] b[4] = '{16'h0201, 16'h0211, 16'h0221, 16'h0231};
        for (int i = 0; i < 8; i++)
        begin
            fkind = 4'(3 + i / 2);
            fat = 3'(i % 2);
            run(1'b1, b[i / 2] + 16'(3 * (i % 2)), "t2_fault");
        end
        fkind = 4'h7;
        fat = 3'h0;
        run(1'b1, 16'h0201, "t2_cap");
        fkind = 4'h0;
    endtask

    task automatic t_abort;
        st1 = 1'b1;
        repeat (2) @(negedge clk);
        st1 = 1'b0;
        repeat (200) @(negedge clk);
        stop = 1'b1;
        @(negedge clk);
        stop = 1'b0;
        repeat (3) @(negedge clk);
        check("stop", status, PST_MSG_STOP);
        check("stop_off", {10'h000, sw}, 16'h0000);
        st2 = 1'b1;
        repeat (2) @(negedge clk);
        st2 = 1'b0;
        repeat (200) @(negedge clk);
        intf = 1'b1;
        @(negedge clk);
        intf = 1'b0;
        repeat (3) @(negedge clk);
        check("internal", status, PST_MSG_INT);
        check("internal_busy", {15'h0000, busy}, 16'h0000);
    endtask

    initial
    begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        t_refuse();
        t1_pass();
        t1_faults();
        t2_pass();
        t2_faults();
        t_abort();
        stop_test();
    end

    // generous bound on the whole sequence of runs
    initial
    begin
        #(90000 * 10);
        failures++;
        stop_test();
    end
endmodule
